// ===== rtl/stl_limiter.sv
// design: position smoothing, speed ramp/clamp, torque limits and overload alarm
`default_nettype none

// register map, one 32-bit word each, settings in the low 16 bits
//   0x00 position smoothing time, ms
//   0x04 speed acceleration time, ms
//   0x08 speed deceleration time, ms
//   0x0C internal ccw torque limit, %
//   0x10 internal cw torque limit, signed %
//   0x14 external ccw torque limit, %
//   0x18 external cw torque limit, signed %
//   0x1C test-run torque limit, %
//   0x20 ccw overload threshold, %
//   0x24 cw overload threshold, signed %
//   0x28 overload detect time, 10 ms units
//   0x2C maximum speed, r/min
//   0x30 jog speed, r/min
//   0x34 control: [2:0] mode, [3] jog direction
//   0x38 status, write one to clear: [0] overload, [1] speed clamped
//   0x3C interrupt mask, same layout as status
//   0x40 effective torque limits, read only
//   0x44 speed reference, read only
// modes: 0 position, 1 speed, 2 torque, 3 jog, 4 keypad, 5 demo
// unmapped addresses answer with a slave error and read zero
// every transfer takes exactly one wait state
// limit-enable pins pass two flops, so limits lag them by three cycles
// all ms figures count control update ticks of TICK_CYCLES clocks
// hazard: a larger TICK_CYCLES slows every ramp and timer alike

// Contract
// - position pulses pass an exponential filter, time constant in ms, none lost.
// - smoothing time zero passes pulses straight through.
// - speed rises zero to rated in the programmed acceleration time.
// - speed falls rated to zero in the programmed deceleration time.
// - smaller speed changes take proportionally less ramp time.
// - ramps act in speed modes only, never in position control.
// - internal ccw torque limit always applies.
// - internal cw torque limit, non-positive, always applies.
// - any limit above the system maximum uses the system maximum.
// - ccw enable input on: ccw limit is least of system, internal, external.
// - cw enable input on: cw limit is least magnitude of the three.
// - ccw torque above threshold beyond detect time raises alarm and stops.
// - cw torque beyond threshold beyond detect time raises alarm and stops.
// - detect time counts 10 ms units; zero disables the alarm.
// - speed clamped to maximum setting, then to system maximum.
// - jog drives at the jog speed setting.
module stl_limiter
  import stl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = STL_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_pulse,
  input wire logic cmd_dir,
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] motor_torque,
  input wire logic ccw_limit_enable_input,
  input wire logic cw_limit_enable_input,
  output logic pos_pulse_out,
  output logic pos_dir_out,
  output logic [15:0] speed_ref,
  output stl_limits_s torque_limits,
  output logic torque_overload_alarm,
  output logic motor_stop,
  output logic irq
);

  logic [15:0] cfg_r [STL_CFG_NUM];
  logic [3:0] ctrl_r;
  logic [STL_STS_W-1:0] sts_r, sts_nxt, mask_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, irq_r;
  logic [1:0] ccw_sync_r, cw_sync_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;

  // two-flop synchronisers for the limit-enable pins
  // the pins come from another domain, so only the second flop is read
  // reset level is low: limits start relaxed, as with pins released
  // cost: three cycles from pin change to new limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccw_sync_r <= 2'b00;
      cw_sync_r <= 2'b00;
    end else begin
      ccw_sync_r <= {ccw_sync_r[0], ccw_limit_enable_input};
      cw_sync_r <= {cw_sync_r[0], cw_limit_enable_input};
    end
  end

  // 1 ms control update tick
  // one-cycle enable pulse, the only slow rate in the block
  // ramp budget, smoothing and overload timer all step on it
  // registered so that the pulse leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // apb decode: one wait state, answer registered
  // first access cycle captures read data and error
  // second access cycle shows pready, where writes land
  // settings decode by word index, the rest by full byte address
  // misaligned settings addresses count as unmapped
  // read-only words ignore writes without an error
  wire apb_access = psel && penable;
  wire apb_done = apb_access && pready_r;
  wire apb_wr = apb_done && pwrite;
  wire [5:0] word_idx = paddr[7:2];
  wire is_cfg = (paddr <= STL_OFS_CFG_LAST) && (paddr[1:0] == 2'b00);
  wire is_ctrl = (paddr == STL_OFS_CTRL);
  wire is_sts = (paddr == STL_OFS_STATUS);
  wire is_mask = (paddr == STL_OFS_MASK);
  wire is_lim = (paddr == STL_OFS_LIMITS);
  wire is_spd = (paddr == STL_OFS_SPEED);
  wire mapped = is_cfg || is_ctrl || is_sts || is_mask || is_lim || is_spd;
  wire [31:0] rd_cfg = is_cfg ? {16'h0000, cfg_r[word_idx[3:0]]} : 32'h0000_0000;
  wire [31:0] rd_mux = is_cfg ? rd_cfg :
                       is_ctrl ? {28'h000_0000, ctrl_r} :
                       is_sts ? {30'h0000_0000, sts_r} :
                       is_mask ? {30'h0000_0000, mask_r} :
                       is_lim ? torque_limits :
                       is_spd ? {16'h0000, speed_ref} : 32'h0000_0000;

  // apb answer flops
  // pready stands one cycle; prdata holds until the next access
  // pslverr rides with pready only for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apb_access && !pready_r;
      pslverr_r <= apb_access && !pready_r && !mapped;
      if (apb_access && !pready_r) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // settings and control writes
  // one flop group per setting word, reset to its default
  // only the low 16 bits are kept; negatives stay two's complement
  generate
    for (genvar i = 0; i < STL_CFG_NUM; i++) begin : g_cfg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_r[i] <= STL_CFG_RST[i];
        end else if (apb_wr && is_cfg && word_idx == 6'(i)) begin
          cfg_r[i] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= STL_CTRL_RST;
      mask_r <= '0;
    end else begin
      if (apb_wr && is_ctrl) ctrl_r <= pwdata[3:0];
      if (apb_wr && is_mask) mask_r <= pwdata[STL_STS_W-1:0];
    end
  end

  // operating mode
  // undefined mode codes act like position control
  // test-run modes are jog, keypad and demo
  // ramps act in speed and test-run modes only
  wire stl_mode_e mode = stl_mode_e'(ctrl_r[STL_CTRL_MODE_LSB +: 3]);
  wire test_run = (mode == STL_MODE_JOG) || (mode == STL_MODE_KEYPAD) || (mode == STL_MODE_DEMO);
  wire ramp_mode = (mode == STL_MODE_SPD) || test_run;

  // ---------------- position command smoothing ----------------
  // pending holds commanded minus emitted counts, signed
  // each tick adds the pending magnitude to the accumulator
  // every time constant of accumulator releases one pulse
  // so the output rate is pending over T: an exponential approach
  // no count is dropped; the filter only delays
  // limitation: at most one output pulse per clock
  // with time zero the pulse passes after two cycles
  logic signed [31:0] pend_r;
  logic [31:0] acc_r;
  logic pulse_r, pdir_r;
  wire [31:0] tconst = {16'h0000, cfg_r[STL_IDX_SMOOTH]};
  wire smooth_off = (tconst == 32'h0000_0000);
  wire [31:0] pend_mag = pend_r[31] ? 32'(-pend_r) : 32'(pend_r);
  // emit at pending/T pulses per ms: exponential approach
  wire emit = (pend_r != 0) && (smooth_off || acc_r >= tconst);
  wire signed [31:0] in_delta = !cmd_pulse ? 32'sd0 : (cmd_dir ? -32'sd1 : 32'sd1);
  wire signed [31:0] out_delta = !emit ? 32'sd0 : (pend_r[31] ? -32'sd1 : 32'sd1);
  wire [31:0] acc_add = tick_r ? pend_mag : 32'h0000_0000;
  wire [31:0] acc_sub = (emit && !smooth_off) ? tconst : 32'h0000_0000;

  // pending count keeps every pulse; output only delayed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 32'sd0;
      acc_r <= 32'h0000_0000;
      pulse_r <= 1'b0;
      pdir_r <= 1'b0;
    end else begin
      pend_r <= pend_r + in_delta - out_delta;
      acc_r <= (smooth_off || pend_r == 0) ? 32'h0000_0000 : acc_r + acc_add - acc_sub;
      pulse_r <= emit;
      if (emit) pdir_r <= pend_r[31];
    end
  end

  // ---------------- speed target, clamp, ramp ----------------
  // target comes from the speed command or, in jog, the jog setting
  // magnitude clamped to the maximum setting, then the system maximum
  // an active overload alarm forces the target to zero
  // each tick adds rated r/min of budget; each step spends ramp time
  // so rated speed takes the ramp time, smaller changes less
  // accel while the magnitude grows in one sign, decel otherwise
  // bypass jumps straight to the target in one cycle
  wire [15:0] max_set = cfg_r[STL_IDX_MAX_SPD];
  wire [15:0] spd_lim = (max_set > STL_SYS_MAX_RPM) ? STL_SYS_MAX_RPM : max_set;
  wire [15:0] jog_spd = cfg_r[STL_IDX_JOG_SPD];
  wire signed [15:0] raw_tgt = (mode == STL_MODE_JOG) ?
                       (ctrl_r[STL_CTRL_JOG_DIR] ? 16'(-$signed(jog_spd)) : $signed(jog_spd)) :
                       $signed(speed_cmd);
  wire [15:0] raw_mag = raw_tgt[15] ? 16'(-raw_tgt) : 16'(raw_tgt);
  wire clamp_hit = raw_mag > spd_lim;
  wire signed [15:0] lim_tgt = !clamp_hit ? raw_tgt :
                       (raw_tgt[15] ? 16'(-$signed(spd_lim)) : $signed(spd_lim));
  wire signed [15:0] tgt = sts_r[STL_STS_OVL] ? 16'sd0 : lim_tgt;
  logic signed [15:0] ref_r;
  logic [31:0] frac_r;
  wire [15:0] ref_mag = ref_r[15] ? 16'(-ref_r) : 16'(ref_r);
  wire [15:0] tgt_mag = tgt[15] ? 16'(-tgt) : 16'(tgt);
  wire speeding_up = (ref_r == 0) || ((ref_r[15] == tgt[15]) && (tgt_mag > ref_mag));
  wire [31:0] ramp_t = {16'h0000, speeding_up ? cfg_r[STL_IDX_ACCEL] : cfg_r[STL_IDX_DECEL]};
  wire ramp_bypass = !ramp_mode || (ramp_t == 32'h0000_0000);
  // one r/min step per spent ramp_t of budget; rated r/min budget per ms
  wire step = (ref_r != tgt) && (frac_r >= ramp_t);
  wire [31:0] frac_add = tick_r ? {16'h0000, STL_RATED_RPM} : 32'h0000_0000;
  wire [31:0] frac_sub = step ? ramp_t : 32'h0000_0000;

  // speed reference follows the ramp or jumps when bypassed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r <= 16'sd0;
      frac_r <= 32'h0000_0000;
    end else if (ramp_bypass) begin
      ref_r <= tgt;
      frac_r <= 32'h0000_0000;
    end else begin
      if (step) ref_r <= (tgt > ref_r) ? ref_r + 16'sd1 : ref_r - 16'sd1;
      frac_r <= (ref_r == tgt) ? 32'h0000_0000 : frac_r + frac_add - frac_sub;
    end
  end

  // ---------------- torque limits ----------------
  // all limits worked as magnitudes, cw turned negative at the end
  // wrong-signed settings count as zero torque
  // disabled external and test limits fall back to the system maximum
  // the effective limit is the least of all that apply
  // recomputed every cycle, so any setting or mode change shows one cycle later
  function automatic logic [15:0] pos_mag(input logic [15:0] v);
    pos_mag = v[15] ? 16'h0000 : v;
  endfunction
  function automatic logic [15:0] neg_mag(input logic [15:0] v);
    neg_mag = v[15] ? 16'(-$signed(v)) : 16'h0000;
  endfunction
  function automatic logic [15:0] min2(input logic [15:0] a, input logic [15:0] b);
    min2 = (a < b) ? a : b;
  endfunction

  wire [15:0] ccw_int = min2(pos_mag(cfg_r[STL_IDX_INT_CCW]), STL_SYS_MAX_TRQ);
  wire [15:0] cw_int = min2(neg_mag(cfg_r[STL_IDX_INT_CW]), STL_SYS_MAX_TRQ);
  wire [15:0] ccw_ext = ccw_sync_r[1] ? pos_mag(cfg_r[STL_IDX_EXT_CCW]) : STL_SYS_MAX_TRQ;
  wire [15:0] cw_ext = cw_sync_r[1] ? neg_mag(cfg_r[STL_IDX_EXT_CW]) : STL_SYS_MAX_TRQ;
  wire [15:0] test_lim = test_run ? pos_mag(cfg_r[STL_IDX_TEST_TRQ]) : STL_SYS_MAX_TRQ;
  wire [15:0] ccw_eff = min2(min2(ccw_int, ccw_ext), test_lim);
  wire [15:0] cw_eff = min2(min2(cw_int, cw_ext), test_lim);
  stl_limits_s lim_r;

  // recomputed each cycle, so each update sees current inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_r <= '0;
    end else begin
      lim_r.ccw <= ccw_eff;
      lim_r.cw <= 16'(-$signed(cw_eff));
    end
  end

  // ---------------- torque overload supervision ----------------
  // torque must stay strictly beyond a threshold, without a break
  // any cycle back inside the thresholds restarts the count
  // detect time counts 10 ms units, turned into ticks
  // time zero switches the whole alarm off
  // the count saturates once the alarm fires
  wire signed [15:0] trq = $signed(motor_torque);
  wire [31:0] ovl_time = {16'h0000, cfg_r[STL_IDX_OVL_TIME]};
  wire [31:0] ovl_ticks = 32'(ovl_time * STL_OVL_UNIT_MS / STL_TICK_MS);
  wire ovl_en = (ovl_time != 32'h0000_0000);
  wire over_ccw = trq > $signed(cfg_r[STL_IDX_OVL_CCW]);
  wire over_cw = trq < $signed(cfg_r[STL_IDX_OVL_CW]);
  wire over = ovl_en && (over_ccw || over_cw);
  logic [31:0] ovl_cnt_r;
  wire ovl_evt = over && (ovl_cnt_r >= ovl_ticks);

  // counts whole ms ticks while overloaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_cnt_r <= 32'h0000_0000;
    end else if (!over) begin
      ovl_cnt_r <= 32'h0000_0000;
    end else if (tick_r && !ovl_evt) begin
      ovl_cnt_r <= ovl_cnt_r + 32'h0000_0001;
    end
  end

  // ---------------- status, interrupt, outputs ----------------
  // sticky status bits, cleared by writing ones
  // an event in the clear cycle keeps its bit set
  // a still-present overload sets the bit again at once
  // interrupt is a level, high while an unmasked bit is set
  // it changes in the same cycle as status
  wire [STL_STS_W-1:0] evts = {clamp_hit, ovl_evt};
  wire [STL_STS_W-1:0] w1c = (apb_wr && is_sts) ? pwdata[STL_STS_W-1:0] : '0;
  assign sts_nxt = (sts_r & ~w1c) | evts;  // set wins over clear

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= '0;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      irq_r <= |(sts_nxt & mask_r);
    end
  end

  // every output comes straight from a flop
  // alarm and motor stop share the overload status bit
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pos_pulse_out = pulse_r;
  assign pos_dir_out = pdir_r;
  assign speed_ref = ref_r;
  assign torque_limits = lim_r;
  assign torque_overload_alarm = sts_r[STL_STS_OVL];
  assign motor_stop = sts_r[STL_STS_OVL];
  assign irq = irq_r;

endmodule
`default_nettype wire

// ===== rtl/stl_pkg.sv
// package: register map, reset values, timing and types of the torque/speed limiter
`default_nettype none
package stl_pkg;
  // clock and time base
  localparam int unsigned STL_CLK_HZ = 50_000_000;
  localparam int unsigned STL_TICK_MS = 1;  // control update period, ms
  localparam int unsigned STL_MS_CYCLES = STL_CLK_HZ / 1000 * STL_TICK_MS;
  localparam int unsigned STL_OVL_UNIT_MS = 10;  // overload time unit, ms

  // system capabilities and rated values (plain defaults)
  localparam logic [15:0] STL_SYS_MAX_TRQ = 16'h012C;  // 300 %
  localparam logic [15:0] STL_SYS_MAX_RPM = 16'h1388;  // 5000 r/min
  localparam logic [15:0] STL_RATED_RPM = 16'h0BB8;  // 3000 r/min

  // settings array: word index = byte offset / 4
  localparam int STL_CFG_NUM = 13;
  localparam int STL_IDX_SMOOTH = 0;
  localparam int STL_IDX_ACCEL = 1;
  localparam int STL_IDX_DECEL = 2;
  localparam int STL_IDX_INT_CCW = 3;
  localparam int STL_IDX_INT_CW = 4;
  localparam int STL_IDX_EXT_CCW = 5;
  localparam int STL_IDX_EXT_CW = 6;
  localparam int STL_IDX_TEST_TRQ = 7;
  localparam int STL_IDX_OVL_CCW = 8;
  localparam int STL_IDX_OVL_CW = 9;
  localparam int STL_IDX_OVL_TIME = 10;
  localparam int STL_IDX_MAX_SPD = 11;
  localparam int STL_IDX_JOG_SPD = 12;

  localparam logic [15:0] STL_CFG_RST [STL_CFG_NUM] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h012C, 16'hFED4, 16'h0064, 16'hFF9C,
    16'h0064, 16'h012C, 16'hFED4, 16'h0000, 16'h0DAC, 16'h0064};

  // byte offsets of the remaining registers
  localparam logic [7:0] STL_OFS_CFG_LAST = 8'h30;
  localparam logic [7:0] STL_OFS_CTRL = 8'h34;
  localparam logic [7:0] STL_OFS_STATUS = 8'h38;
  localparam logic [7:0] STL_OFS_MASK = 8'h3C;
  localparam logic [7:0] STL_OFS_LIMITS = 8'h40;
  localparam logic [7:0] STL_OFS_SPEED = 8'h44;

  // control register fields
  localparam int STL_CTRL_MODE_LSB = 0;
  localparam int STL_CTRL_JOG_DIR = 3;
  localparam logic [3:0] STL_CTRL_RST = 4'h0;

  // status / mask bits
  localparam int STL_STS_W = 2;
  localparam int STL_STS_OVL = 0;
  localparam int STL_STS_CLAMP = 1;

  typedef enum logic [2:0] {
    STL_MODE_POS, STL_MODE_SPD, STL_MODE_TRQ, STL_MODE_JOG, STL_MODE_KEYPAD, STL_MODE_DEMO
  } stl_mode_e;

  // effective torque limits: ccw positive %, cw signed non-positive %
  typedef struct packed {
    logic [15:0] ccw;
    logic [15:0] cw;
  } stl_limits_s;
endpackage
`default_nettype wire

// ===== bench/stl_host_model.sv
// partner: upper controller sending bursts of position command pulses
`default_nettype none
module stl_host_model
  import stl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [7:0] n_req,
  input wire logic go_dir,
  output logic cmd_pulse,
  output logic cmd_dir
);
  logic [7:0] left_r;
  // one pulse per cycle until the burst is spent, direction held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= '0;
      cmd_dir <= 1'b0;
    end else if (go) begin
      left_r <= n_req;
      cmd_dir <= go_dir;
    end else if (left_r != '0) begin
      left_r <= left_r - 8'h01;
    end
  end
  assign cmd_pulse = left_r != '0;
endmodule
`default_nettype wire

// ===== bench/stl_limiter_chk.sv
// checker: port-level properties of the torque and speed limiter
`default_nettype none
module stl_limiter_chk
  import stl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] motor_torque,
  input wire logic [15:0] speed_ref,
  input wire stl_limits_s torque_limits,
  input wire logic torque_overload_alarm,
  input wire logic motor_stop
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // completed write of a one to the overload status bit
  wire logic ovl_clr;
  assign ovl_clr = psel && penable && pready && pwrite && paddr == STL_OFS_STATUS && pwdata[0];
  property p_ccw_max; torque_limits.ccw <= STL_SYS_MAX_TRQ; endproperty
  a_ccw_max: assert property (p_ccw_max) else $error("ccw limit above system max");
  property p_ccw_sign; !torque_limits.ccw[15]; endproperty
  a_ccw_sign: assert property (p_ccw_sign) else $error("ccw limit negative");
  property p_cw_rng;
    torque_limits.cw == '0 ||
      (torque_limits.cw[15] && $signed(torque_limits.cw) >= -$signed(STL_SYS_MAX_TRQ));
  endproperty
  a_cw_rng: assert property (p_cw_rng) else $error("cw limit out of range");
  property p_spd_max;
    $signed(speed_ref) <= $signed(STL_SYS_MAX_RPM) &&
      $signed(speed_ref) >= -$signed(STL_SYS_MAX_RPM);
  endproperty
  a_spd_max: assert property (p_spd_max) else $error("speed above system max");
  property p_stop; motor_stop == torque_overload_alarm; endproperty
  a_stop: assert property (p_stop) else $error("stop differs from alarm");
  property p_hold; torque_overload_alarm && !ovl_clr |=> torque_overload_alarm; endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped without clear");
  property p_cause;
    $rose(torque_overload_alarm) |-> $past(motor_torque) != '0 || $past(motor_torque, 2) != '0;
  endproperty
  a_cause: assert property (p_cause) else $error("alarm with zero torque");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready && psel && penable && $past(psel && penable); endproperty
  a_err: assert property (p_err) else $error("error outside access");
endmodule
bind stl_limiter stl_limiter_chk u_stl_limiter_chk (.*);
`default_nettype wire

// ===== bench/tb.sv
// testbench: registers, torque limits, speed shaping, pulses, overload
`default_nettype none
module tb
  import stl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_pulse, cmd_dir, rerr;
  logic ccw_limit_enable_input, cw_limit_enable_input, pos_pulse_out, pos_dir_out;
  logic torque_overload_alarm, motor_stop, irq, go, go_dir;
  logic [7:0] paddr, n_req;
  logic [15:0] speed_cmd, motor_torque, speed_ref;
  logic [31:0] pwdata, prdata, rdat;
  stl_limits_s torque_limits;
  int fail_count = 0;
  int compares = 0;
  int pcnt = 0;
  int base;
  stl_limiter #(.TICK_CYCLES(20)) u_stl_limiter (.*);
  stl_host_model u_stl_host_model (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // count smoothed output pulses
  always @(posedge pclk) if (pos_pulse_out === 1'b1) pcnt++;
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [7:0] ofs(input int i);
    return 8'(i * 4);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one transfer, held until ready is sampled high
  task automatic apb(input logic [7:0] a, input logic [15:0] d, input logic w = 1'b1);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {{16{d[15]}}, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) fail_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic lim(input logic [15:0] c, input logic [15:0] w);
    cyc(4);
    chk("ccw limit", 32'(torque_limits.ccw), 32'(c));
    chk("cw limit", 32'(torque_limits.cw), 32'(w));
  endtask
  task automatic spd(input logic [15:0] v);
    cyc(4);
    chk("speed", 32'(speed_ref), 32'(v));
  endtask
  task automatic burst(input logic [7:0] n, input logic d);
    base = pcnt;
    n_req <= n;
    go_dir <= d;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cut a hang short
  initial begin
    cyc(30000);
    fail_count++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, go, go_dir, ccw_limit_enable_input} = '0;
    {cw_limit_enable_input, paddr, n_req, speed_cmd, motor_torque, pwdata} = '0;
    cyc(20);
    presetn <= 1'b1;
    @(posedge pclk);
    lim(16'h012C, 16'hFED4);
    for (int i = 0; i < STL_CFG_NUM; i++) begin
      apb(ofs(i), '0, 1'b0);
      chk("setting", 32'(rdat[15:0]), 32'(STL_CFG_RST[i]));
    end
    apb(8'h80, 16'h1234);
    chk("slave error", 32'(rerr), 32'h0000_0001);
    apb(8'h80, '0, 1'b0);
    chk("unmapped data", rdat, 32'h0000_0000);
    $display("test registers done");
    apb(ofs(STL_IDX_INT_CCW), 16'h0190);
    apb(ofs(STL_IDX_INT_CW), 16'hFE70);
    lim(16'h012C, 16'hFED4);
    apb(ofs(STL_IDX_INT_CCW), 16'h00C8);
    apb(ofs(STL_IDX_INT_CW), 16'hFF06);
    lim(16'h00C8, 16'hFF06);
    ccw_limit_enable_input <= 1'b1;
    lim(16'h0064, 16'hFF06);
    apb(ofs(STL_IDX_EXT_CCW), 16'h00FA);
    cw_limit_enable_input <= 1'b1;
    lim(16'h00C8, 16'hFF9C);
    ccw_limit_enable_input <= 1'b0;
    cw_limit_enable_input <= 1'b0;
    apb(ofs(STL_IDX_TEST_TRQ), 16'h0032);
    for (int m = 3; m < 6; m++) begin
      apb(STL_OFS_CTRL, 16'(m));
      lim(16'h0032, 16'hFFCE);
    end
    apb(STL_OFS_CTRL, 16'h0001);
    lim(16'h00C8, 16'hFF06);
    $display("test torque done");
    apb(ofs(STL_IDX_MAX_SPD), 16'h1770);
    speed_cmd <= 16'h1770;
    spd(16'h1388);
    apb(ofs(STL_IDX_MAX_SPD), 16'h03E8);
    speed_cmd <= 16'hF830;
    spd(16'hFC18);
    apb(STL_OFS_CTRL, 16'h0003);
    spd(16'h0064);
    apb(STL_OFS_CTRL, 16'h000B);
    spd(16'hFF9C);
    apb(STL_OFS_CTRL, 16'h0001);
    speed_cmd <= 16'h0000;
    cyc(10);
    apb(ofs(STL_IDX_ACCEL), 16'h012C);
    apb(ofs(STL_IDX_DECEL), 16'h012C);
    for (int k = 0; k < 2; k++) begin
      speed_cmd <= k ? 16'h0000 : 16'h012C;
      cyc(300);
      chk("ramp mid", 32'(speed_ref > 16'h0000 && speed_ref < 16'h012C), 1);
      cyc(396);
      spd(k ? 16'h0000 : 16'h012C);
      chk("ramp end", 32'(speed_ref), k ? 32'h0000_0000 : 32'h0000_012C);
    end
    apb(STL_OFS_CTRL, 16'h0000);
    speed_cmd <= 16'h012C;
    spd(16'h012C);
    $display("test speed done");
    apb(ofs(STL_IDX_ACCEL), 16'h0000);
    apb(ofs(STL_IDX_DECEL), 16'h0000);
    burst(8'd5, 1'b0);
    cyc(9);
    chk("direct pulses", 32'(pcnt - base), 32'h0000_0005);
    apb(ofs(STL_IDX_SMOOTH), 16'h0005);
    burst(8'd40, 1'b1);
    cyc(45);
    chk("smoothing delay", 32'(pcnt - base < 40), 32'h0000_0001);
    cyc(4000);
    chk("smoothed pulses", 32'(pcnt - base), 32'h0000_0028);
    chk("pulse direction", 32'(pos_dir_out), 32'h0000_0001);
    $display("test pulses done");
    apb(ofs(STL_IDX_OVL_CCW), 16'h0064);
    apb(ofs(STL_IDX_OVL_CW), 16'hFF9C);
    apb(ofs(STL_IDX_OVL_TIME), 16'h0001);
    apb(STL_OFS_MASK, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      motor_torque <= k ? 16'hFF6A : 16'h0096;
      cyc(150);
      chk("early alarm", 32'(torque_overload_alarm), 32'h0000_0000);
      cyc(100);
      chk("alarm", 32'(torque_overload_alarm), 32'h0000_0001);
      chk("irq set", 32'(irq), 32'h0000_0001);
      motor_torque <= 16'h0000;
      apb(STL_OFS_STATUS, 16'h0001);
      cyc(3);
      chk("alarm cleared", 32'(torque_overload_alarm | irq), 32'h0000_0000);
    end
    apb(ofs(STL_IDX_OVL_TIME), 16'h0000);
    motor_torque <= 16'hFF6A;
    cyc(400);
    chk("alarm disabled", 32'(torque_overload_alarm), 32'h0000_0000);
    $display("test overload done");
    print_verdict();
  end
endmodule
`default_nettype wire
